// File: pcicfg_defs.svh
// Purpose: Named constants for the configuration identification and command block
// Assumes: Configuration header addressed as 64 dwords of 32 bits
// Notes:   Included by bare name; definitions only
`ifndef PCICFG_DEFS_SVH
`define PCICFG_DEFS_SVH

`define PCICFG_DWORD_BITS        6
`define PCICFG_ID_DWORD          6'h00
`define PCICFG_CMD_DWORD         6'h01
`define PCICFG_CMD_RESET         16'h0000
`define PCICFG_CMD_WRITABLE      16'h0147
`define PCICFG_CMD_RSVD_MASK     16'hFC00
`define PCICFG_CMD_FIXED_MASK    16'h02B8
`define PCICFG_BIT_IO            0
`define PCICFG_BIT_MEM           1
`define PCICFG_BIT_INITIATOR     2
`define PCICFG_BIT_SPECIAL       3
`define PCICFG_BIT_WR_INVAL      4
`define PCICFG_BIT_PALETTE       5
`define PCICFG_BIT_PARITY        6
`define PCICFG_BIT_STEPPING      7
`define PCICFG_BIT_SYSERR        8
`define PCICFG_BIT_FAST_B2B      9
`define PCICFG_ZERO_WORD         16'h0000

`endif

// File: pcicfg_pkg.sv
// Purpose: Types shared by the configuration identification and command block
// Assumes: Constants come from pcicfg_defs.svh
// Notes:   Structs carry the configuration request and the fixed feature outputs
`default_nettype none
`include "pcicfg_defs.svh"

package pcicfg_pkg;

	typedef struct packed {
		logic                            write;
		logic [`PCICFG_DWORD_BITS-1:0]   dword_index;
		logic [3:0]                      byte_en;
		logic [31:0]                     wdata;
	} pcicfg_request_type;

	typedef struct packed {
		logic fast_back_to_back_use;
		logic stepping_use;
		logic palette_snoop_use;
		logic write_invalidate_use;
		logic special_cycle_claim;
	} pcicfg_feature_type;

endpackage

`default_nettype wire

// File: pcicfg_lane_merge.sv
// Purpose: Byte-lane merge of a write into a register with a writable mask
// Assumes: WIDTH is a multiple of eight
// Notes:   Purely combinational
`default_nettype none

module pcicfg_lane_merge #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0]   current,
	input  wire logic [WIDTH-1:0]   wdata,
	input  wire logic [WIDTH/8-1:0] lane_en,
	input  wire logic [WIDTH-1:0]   writable,
	output logic      [WIDTH-1:0]   merged
);
	genvar lane;
	generate
		for (lane = 0; lane < WIDTH/8; lane = lane + 1)
		begin : g_lane
			// Read-only bits keep their value even inside an enabled lane
			assign merged[lane*8 +: 8] = lane_en[lane]
				? ((wdata[lane*8 +: 8] & writable[lane*8 +: 8])
					| (current[lane*8 +: 8] & ~writable[lane*8 +: 8]))
				: current[lane*8 +: 8];
		end
	endgenerate
endmodule // pcicfg_lane_merge

`default_nettype wire

// File: pcicfg_regs.sv
// Purpose: Identification words and command register of a configuration header
// Assumes: Bus logic on clk decodes configuration cycles into one-cycle requests
// Notes:   Answer is registered one cycle after each request
`default_nettype none
`include "pcicfg_defs.svh"

// Notes on behaviour
// - Maker identification at offset zero, read-only
// - Part identification at offset two, read-only
// - Command bits fifteen to ten read zero
// - Fast back-to-back bit zero, never used
// - Bit eight enables the system error driver
// - Address parity reported only with bits eight, six
// - Stepping bit hardwired zero, never used
// - Bit six enables parity error response
// - Palette snoop bit zero, never snooped
// - Write-invalidate bit zero, plain writes used
// - Special cycle bit zero, never claimed
// - Bit two gates bus initiator requests
// - Bit one gates memory space claims
// - Bit zero gates I/O space claims
// - Registers live in 256-byte configuration header
module pcicfg_regs
	import pcicfg_pkg::*;
#(
	// Arbitrary neutral identity values
	parameter logic [15:0] MAKER_ID = 16'h5A5A,
	parameter logic [15:0] PART_ID  = 16'h0101
) (
	input  wire logic                           clk,
	input  wire logic                           sys_rst,
	input  wire logic                           cfg_req,
	input  wire pcicfg_pkg::pcicfg_request_type cfg_request,
	output logic                                cfg_ack,
	output logic [31:0]                         cfg_rdata,
	input  wire logic                           core_initiator_req,
	output logic                                bus_initiator_req,
	input  wire logic                           memory_hit,
	output logic                                memory_claim,
	input  wire logic                           io_hit,
	output logic                                io_claim,
	input  wire logic                           address_parity_error,
	input  wire logic                           data_parity_error,
	output logic                                system_error_assert,
	output logic                                parity_error_assert,
	output logic [15:0]                         bus_interface_control,
	output pcicfg_pkg::pcicfg_feature_type      feature_use
);
	import pcicfg_pkg::*;

	logic [15:0] next_control;
	logic        cmd_write;
	logic        system_error_drive_enable;
	logic        parity_response_enable;
	logic        bus_initiator_enable;
	logic        fast_back_to_back_enable;
	logic        write_invalidate_enable;

	assign cmd_write = cfg_req && cfg_request.write
		&& (cfg_request.dword_index == `PCICFG_CMD_DWORD);

	pcicfg_lane_merge #(
		.WIDTH(16)
	) u_merge (
		.current  (bus_interface_control),
		.wdata    (cfg_request.wdata[15:0]),
		.lane_en  (cfg_request.byte_en[1:0]),
		.writable (`PCICFG_CMD_WRITABLE),
		.merged   (next_control)
	);

	// Identity dword is never written; mask keeps fixed bits at zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			bus_interface_control <= `PCICFG_CMD_RESET;
		else if (cmd_write)
			bus_interface_control <= next_control;
	end

	assign system_error_drive_enable = bus_interface_control[`PCICFG_BIT_SYSERR];
	assign parity_response_enable    = bus_interface_control[`PCICFG_BIT_PARITY];
	assign bus_initiator_enable      = bus_interface_control[`PCICFG_BIT_INITIATOR];
	assign fast_back_to_back_enable  = bus_interface_control[`PCICFG_BIT_FAST_B2B];
	assign write_invalidate_enable   = bus_interface_control[`PCICFG_BIT_WR_INVAL];

	// Unmapped dwords of the header answer zero so probing is harmless
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= {`PCICFG_ZERO_WORD, `PCICFG_ZERO_WORD};
		end
		else
		begin
			cfg_ack <= cfg_req;
			if (cfg_req && !cfg_request.write)
			begin
				case (cfg_request.dword_index)
					`PCICFG_ID_DWORD:  cfg_rdata <= {PART_ID, MAKER_ID};
					`PCICFG_CMD_DWORD: cfg_rdata <= {`PCICFG_ZERO_WORD, bus_interface_control};
					default:           cfg_rdata <= {`PCICFG_ZERO_WORD, `PCICFG_ZERO_WORD};
				endcase
			end
		end
	end

	// Gates are combinational so a claim is not delayed past decode
	assign bus_initiator_req = core_initiator_req && bus_initiator_enable;
	assign memory_claim = memory_hit && bus_interface_control[`PCICFG_BIT_MEM];
	assign io_claim     = io_hit && bus_interface_control[`PCICFG_BIT_IO];

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			system_error_assert <= 1'b0;
			parity_error_assert <= 1'b0;
		end
		else
		begin
			system_error_assert <= address_parity_error
				&& system_error_drive_enable && parity_response_enable;
			parity_error_assert <= data_parity_error && parity_response_enable;
		end
	end

	// Unsupported features stay off whatever software writes
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			feature_use <= '0;
		else
		begin
			feature_use.fast_back_to_back_use <= fast_back_to_back_enable;
			feature_use.stepping_use <= bus_interface_control[`PCICFG_BIT_STEPPING];
			feature_use.palette_snoop_use <= bus_interface_control[`PCICFG_BIT_PALETTE];
			feature_use.write_invalidate_use <= write_invalidate_enable;
			feature_use.special_cycle_claim <= bus_interface_control[`PCICFG_BIT_SPECIAL];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	ack_timing_a: assert property (
		cfg_req |=> cfg_ack ##1 (!cfg_ack || $past(cfg_req)))
		else $error("configuration answer not one cycle after request");

	id_read_a: assert property (
		cfg_req && !cfg_request.write && cfg_request.dword_index == `PCICFG_ID_DWORD
		|=> cfg_rdata == {PART_ID, MAKER_ID})
		else $error("identity dword read wrong");

	id_write_a: assert property (
		cfg_req && cfg_request.write && cfg_request.dword_index == `PCICFG_ID_DWORD
		|=> $stable(bus_interface_control))
		else $error("identity write disturbed command register");

	reserved_zero_a: assert property (
		(bus_interface_control & `PCICFG_CMD_RSVD_MASK) == `PCICFG_ZERO_WORD)
		else $error("reserved command bits not zero");

	fixed_zero_a: assert property (
		(bus_interface_control & `PCICFG_CMD_FIXED_MASK) == `PCICFG_ZERO_WORD
		##1 feature_use == '0)
		else $error("hardwired command bit or feature became set");

	syserr_gate_a: assert property (
		system_error_assert |-> $past(address_parity_error)
		&& $past(system_error_drive_enable) && $past(parity_response_enable))
		else $error("system error without both enables");

	syserr_fire_a: assert property (
		address_parity_error && system_error_drive_enable && parity_response_enable
		|=> system_error_assert)
		else $error("enabled system error not driven");

	parity_resp_a: assert property (
		##1 parity_error_assert == $past(data_parity_error && parity_response_enable))
		else $error("parity response wrong");

	initiator_gate_a: assert property (
		bus_initiator_req |-> bus_initiator_enable && core_initiator_req)
		else $error("initiator request while disabled");

	space_claim_a: assert property (
		(memory_claim |-> bus_interface_control[`PCICFG_BIT_MEM])
		and (io_claim |-> bus_interface_control[`PCICFG_BIT_IO]))
		else $error("space claim while disabled");

	lane_hold_a: assert property (
		cmd_write && !cfg_request.byte_en[0]
		|=> bus_interface_control[7:0] == $past(bus_interface_control[7:0]))
		else $error("disabled low lane changed");

	lane_write_a: assert property (
		cmd_write && cfg_request.byte_en[1]
		|=> bus_interface_control[`PCICFG_BIT_SYSERR] == $past(cfg_request.wdata[8]))
		else $error("enabled high lane not written");

	// Reset must clear every enable, not only the power-on value
	reset_clear_a: assert property (
		$past(sys_rst) |-> bus_interface_control == `PCICFG_CMD_RESET
		&& !cfg_ack && !system_error_assert && !parity_error_assert)
		else $error("reset left command or answer set");

	cmd_read_a: assert property (
		cfg_req && !cfg_request.write && cfg_request.dword_index == `PCICFG_CMD_DWORD
		|=> cfg_rdata == {`PCICFG_ZERO_WORD, $past(bus_interface_control)})
		else $error("command dword read wrong");

	ack_source_a: assert property (
		cfg_ack |-> $past(cfg_req))
		else $error("configuration answer without request");

	syserr_quiet_a: assert property (
		!address_parity_error |=> !system_error_assert)
		else $error("system error without address parity error");

endmodule // pcicfg_regs

`default_nettype wire

// File: pcicfg_host_model.sv
// Purpose: Host side that issues configuration reads and writes
// Assumes: One access at a time; the answer comes within a few cycles
// Notes:   The bench calls access through the hierarchy
`default_nettype none

module pcicfg_host_model (
	input  wire logic                           clk,
	output var  logic                           cfg_req,
	output var  pcicfg_pkg::pcicfg_request_type cfg_request,
	input  wire logic                           cfg_ack,
	input  wire logic [31:0]                    cfg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	import pcicfg_pkg::*;

	bit timed_out = 1'b0;

	initial
	begin
		cfg_req = 1'b0;
		cfg_request = '0;
	end

	task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		#1;
		cfg_req = 1'b1;
		cfg_request = '{wr, idx, be, wd};
		@(posedge clk);
		#1;
		cfg_req = 1'b0;
		// Released lines must not keep showing the old request
		cfg_request = ~cfg_request;
		n = 0;
		while (cfg_ack !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (cfg_ack !== 1'b1)
			timed_out = 1'b1;
		rd = cfg_rdata;
	endtask
endmodule // pcicfg_host_model

`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the identification and command block
// Assumes: Host model issues one access at a time
// Notes:   Identity values below are arbitrary
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import pcicfg_pkg::*;

	localparam logic [15:0] MAKER = 16'h3C3C;
	localparam logic [15:0] PART  = 16'h0707;
	logic clk = 1'b0, sys_rst = 1'b1, core_initiator_req = 1'b0, memory_hit = 1'b0;
	logic io_hit = 1'b0, address_parity_error = 1'b0, data_parity_error = 1'b0;
	logic cfg_req, cfg_ack, bus_initiator_req, memory_claim, io_claim;
	logic system_error_assert, parity_error_assert;
	logic [31:0] cfg_rdata, rd;
	logic [15:0] bus_interface_control;
	pcicfg_request_type cfg_request;
	pcicfg_feature_type feature_use;
	int err_total = 0;
	int checks = 0;
	logic [15:0] cmd_tab [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
		16'h0040, 16'h0100, 16'h0140, 16'h0147};

	always #5 clk = ~clk;

	pcicfg_regs #(.MAKER_ID(MAKER), .PART_ID(PART)) pcicfg_regs_inst (
		.clk                   (clk),
		.sys_rst               (sys_rst),
		.cfg_req               (cfg_req),
		.cfg_request           (cfg_request),
		.cfg_ack               (cfg_ack),
		.cfg_rdata             (cfg_rdata),
		.core_initiator_req    (core_initiator_req),
		.bus_initiator_req     (bus_initiator_req),
		.memory_hit            (memory_hit),
		.memory_claim          (memory_claim),
		.io_hit                (io_hit),
		.io_claim              (io_claim),
		.address_parity_error  (address_parity_error),
		.data_parity_error     (data_parity_error),
		.system_error_assert   (system_error_assert),
		.parity_error_assert   (parity_error_assert),
		.bus_interface_control (bus_interface_control),
		.feature_use           (feature_use)
	);
	pcicfg_host_model pcicfg_host_model_inst (.clk(clk), .cfg_req(cfg_req),
		.cfg_request(cfg_request), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic acc(input logic wr, input logic [5:0] idx, input logic [3:0] be,
		input logic [31:0] wd);
		pcicfg_host_model_inst.access(wr, idx, be, wd, rd);
		if (pcicfg_host_model_inst.timed_out)
		begin
			err_total++;
			report_and_stop();
		end
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		check("command at reset", 32'(bus_interface_control), 32'h0);
		acc(1'b0, 6'h00, 4'h0, 32'h0);
		check("identity word", rd, {PART, MAKER});
		acc(1'b1, 6'h00, 4'hF, 32'hFFFFFFFF);
		acc(1'b0, 6'h00, 4'h0, 32'h0);
		check("identity after write", rd, {PART, MAKER});
		acc(1'b1, 6'h01, 4'hF, 32'hFFFFFFFF);
		acc(1'b0, 6'h01, 4'h0, 32'h0);
		check("command fixed bits", rd, 32'h00000147);
		check("features off", 32'(feature_use), 32'h0);
		acc(1'b1, 6'h01, 4'h1, 32'h0);
		check("low lane write", 32'(bus_interface_control), 32'h0100);
		acc(1'b1, 6'h01, 4'h2, 32'h0);
		check("high lane write", 32'(bus_interface_control), 32'h0);
		acc(1'b0, 6'h3F, 4'h0, 32'h0);
		check("unmapped dword", rd, 32'h0);
		check("answer pulse", 32'(cfg_ack), 32'h1);
		@(posedge clk);
		#1;
		check("answer ends", 32'(cfg_ack), 32'h0);
		$display("test registers done");
		foreach (cmd_tab[i])
		begin
			acc(1'b1, 6'h01, 4'h3, {16'h0, cmd_tab[i]});
			core_initiator_req = 1'b1;
			memory_hit = 1'b1;
			io_hit = 1'b1;
			address_parity_error = 1'b1;
			data_parity_error = 1'b1;
			@(posedge clk);
			#1;
			address_parity_error = 1'b0;
			data_parity_error = 1'b0;
			check("initiator gate", 32'(bus_initiator_req), 32'(cmd_tab[i][2]));
			check("memory gate", 32'(memory_claim), 32'(cmd_tab[i][1]));
			check("io gate", 32'(io_claim), 32'(cmd_tab[i][0]));
			check("system error", 32'(system_error_assert),
				32'(cmd_tab[i][8] & cmd_tab[i][6]));
			check("parity error", 32'(parity_error_assert), 32'(cmd_tab[i][6]));
			@(posedge clk);
			#1;
			check("system error ends", 32'(system_error_assert), 32'h0);
			check("parity error ends", 32'(parity_error_assert), 32'h0);
			core_initiator_req = 1'b0;
			memory_hit = 1'b0;
			io_hit = 1'b0;
			@(posedge clk);
			#1;
			check("initiator idle", 32'(bus_initiator_req), 32'h0);
			check("memory idle", 32'(memory_claim), 32'h0);
			check("io idle", 32'(io_claim), 32'h0);
		end
		$display("test gates done");
		// Leave read data and enables set so the reset has something to clear
		acc(1'b0, 6'h00, 4'h0, 32'h0);
		sys_rst = 1'b1;
		@(posedge clk);
		#1;
		sys_rst = 1'b0;
		check("command after reset", 32'(bus_interface_control), 32'h0);
		check("answer after reset", 32'(cfg_ack), 32'h0);
		check("data after reset", cfg_rdata, 32'h0);
		acc(1'b0, 6'h01, 4'h0, 32'h0);
		check("command read after reset", rd, 32'h0);
		$display("test reset done");
		report_and_stop();
	end
endmodule // testbench

`default_nettype wire
